// file: hrs_pkg.sv
// Shared constants and types for the hub reset, strap and SMBus-ready sequencer.
// Assumes a single 20 MHz clock shared by both ends of the link.
package hrs_pkg;

    localparam int CLK_PERIOD_NS = 50;

    // Times as printed, in their own units.
    localparam int T_RST_ASSERT_US = 5;
    localparam int T_STRAP_HOLD_MS = 1;
    localparam int T_SMB_READY_MS = 40;
    localparam int T_ATTACH_READY_US = 11500;
    localparam int T_I2C_SM_HALF_NS = 5000;
    localparam int T_I2C_FM_HALF_NS = 1250;

    // Least times round up to whole cycles.
    localparam int RST_ASSERT_CYC = (T_RST_ASSERT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRAP_HOLD_CYC = (T_STRAP_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SMB_READY_CYC = (T_SMB_READY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ATTACH_READY_CYC = (T_ATTACH_READY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 20;
    localparam int STRAP_W = 8;
    localparam int HALF_W = 8;

    localparam logic [HALF_W-1:0] I2C_SM_HALF_CYC = HALF_W'(T_I2C_SM_HALF_NS / CLK_PERIOD_NS);
    localparam logic [HALF_W-1:0] I2C_FM_HALF_CYC = HALF_W'(T_I2C_FM_HALF_NS / CLK_PERIOD_NS);

    localparam logic [15:0] CMD_ATTACH_RUNTIME = 16'hAA56;

    typedef enum logic [2:0] {DS_POR, DS_HELD, DS_RUN, DS_READY, DS_ATTACH} hrs_dev_state_t;
    typedef enum logic [1:0] {HS_RUN, HS_ASSERT, HS_WAIT_CLK} hrs_host_state_t;

endpackage

// file: hrs_link_if.sv
// Link between the hub sequencer and the board logic with its SMBus master.
// Commands are modelled at transaction level: one code per valid/ack handshake.
interface hrs_link_if #(parameter int STRAP_W = 8);
    logic resetN;
    logic [STRAP_W-1:0] strapPins;
    logic cmdValid;
    logic [15:0] cmdCode;
    logic cmdAck;
    logic hubSuspend;
    logic clkForceOn;

    modport device (
        input resetN,
        input strapPins,
        input cmdValid,
        input cmdCode,
        output cmdAck,
        input hubSuspend,
        input clkForceOn
    );

    modport host (
        output resetN,
        output strapPins,
        output cmdValid,
        output cmdCode,
        input cmdAck,
        output hubSuspend,
        output clkForceOn
    );
endinterface

// file: hrs_device.sv
// Hub end: internal power-on reset, strap latching and SMBus slave readiness.
// Commands arrive at transaction level, one code per valid and acknowledge pair.
// Assumes the board keeps reset width, strap hold and bus idle times.
// Assumes the bus wire protocol itself is handled outside this block.
//
// How it works
// - External reset, if used, low at least 5 us.
// - Internal power-on reset alone brings device up.
// - Straps latch again after every external reset.
// - Straps stay stable 1 ms after reset release.
// - Without reset, straps stable 1 ms after power.
// - Before power-on reset ends, power-on timing rules.
// - Clock stable before reset is released.
// - Bus idle 40 ms after power-on or release.
// - Bus idle 11.5 ms after attach command ack.
// - Suspend without forced clocks hides SMBus slave.
// - I2C supports 100 kHz and 400 kHz modes.
module hrs_device
    import hrs_pkg::*;
#(
    // Timing counts in clock cycles; shorter values only speed up simulation.
    parameter int SW = STRAP_W,
    parameter int STRAP_CYC = STRAP_HOLD_CYC,
    parameter int READY_CYC = SMB_READY_CYC,
    parameter int ATTACH_CYC = ATTACH_READY_CYC
)
(
    // Clock and power-on reset.
    input wire logic mclk,
    input wire logic rst,
    // Link to board logic and SMBus master.
    hrs_link_if.device link,
    // Core side.
    input wire logic i2cFastSel,
    output logic [SW-1:0] strapLatched,
    output logic porDone,
    output logic smbReady,
    output logic [HALF_W-1:0] i2cSclHalf
);

    ////////////////////////////////////////////////////////////////////////////////
    // One record holds all state, so the reset image and the next copy cannot drift apart.
    typedef struct packed {
        hrs_dev_state_t st;
        logic [CNT_W-1:0] cnt;
        logic porDone;
        logic [SW-1:0] strap;
        logic ack;
        logic rdy;
        logic sync1;
        logic sync2;
        logic [HALF_W-1:0] half;
    } hrs_dev_t;

    localparam hrs_dev_t DEV_RESET = '{
        st: DS_POR,
        cnt: '0,
        porDone: 1'b0,
        strap: '0,
        ack: 1'b0,
        rdy: 1'b0,
        sync1: 1'b0,
        sync2: 1'b0,
        half: I2C_SM_HALF_CYC
    };

    // End points are one short because counts start at zero, or at RELEASE_LAG after an external release.
    localparam logic [CNT_W-1:0] STRAP_LAST = CNT_W'(STRAP_CYC - 1);
    localparam logic [CNT_W-1:0] READY_LAST = CNT_W'(READY_CYC - 1);
    localparam logic [CNT_W-1:0] ATTACH_LAST = CNT_W'(ATTACH_CYC - 1);
    // Two synchroniser stages plus the edge that leaves the held state.
    localparam logic [CNT_W-1:0] RELEASE_LAG = CNT_W'(32'h0000_0003);

    hrs_dev_t s_r;
    hrs_dev_t s_nxt;
    logic extHeld;
    logic reachable;

    ////////////////////////////////////////////////////////////////////////////////
    // Every counter end point is tested through one decode, so all states compare alike.
    function automatic logic cntAt(input logic [CNT_W-1:0] value, input logic [CNT_W-1:0] last);
        return value == last;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.sync1 = link.resetN;
        s_nxt.sync2 = s_r.sync1;
        // Assertion is seen straight from the pin; release waits for the synchronised copy.
        extHeld = !link.resetN || !s_r.sync2;
        // Suspend stops the slave clocks unless software forced them on.
        reachable = !link.hubSuspend || link.clkForceOn;
        if (i2cFastSel)
        begin
            s_nxt.half = I2C_FM_HALF_CYC;
        end
        else
        begin
            s_nxt.half = I2C_SM_HALF_CYC;
        end
        unique case (s_r.st)
            DS_POR:
            begin
                // Runs from the clock reset alone, so no external pulse is needed.
                s_nxt.cnt = s_r.cnt + 1'b1;
                // Straps are taken at the end of the power-on window, while the board still holds them.
                if (cntAt(s_r.cnt, STRAP_LAST))
                begin
                    s_nxt.strap = link.strapPins;
                    s_nxt.porDone = 1'b1;
                    s_nxt.st = DS_RUN;
                end
            end
            DS_HELD:
            begin
                // The count stays cleared while the pin or its synchronised copy is low.
                s_nxt.cnt = '0;
                if (!extHeld)
                begin
                    // Counting resumes as if from the pin edge, so the strap sample stays inside
                    // the board's hold window and readiness meets the master's idle time.
                    s_nxt.cnt = RELEASE_LAG;
                    s_nxt.st = DS_RUN;
                end
            end
            DS_RUN:
            begin
                s_nxt.cnt = s_r.cnt + 1'b1;
                // After an external release the straps are taken at the end of their hold window.
                if (cntAt(s_r.cnt, STRAP_LAST))
                begin
                    s_nxt.strap = link.strapPins;
                end
                if (cntAt(s_r.cnt, READY_LAST))
                begin
                    s_nxt.st = DS_READY;
                    s_nxt.cnt = '0;
                end
            end
            DS_READY:
            begin
                // One acknowledge per request: the host drops valid only on the edge that sees it.
                if (link.cmdValid && reachable && !s_r.ack)
                begin
                    s_nxt.ack = 1'b1;
                    if (link.cmdCode == CMD_ATTACH_RUNTIME)
                    begin
                        s_nxt.st = DS_ATTACH;
                        s_nxt.cnt = '0;
                    end
                end
            end
            DS_ATTACH:
            begin
                // The slave stays busy while the attach settles.
                s_nxt.cnt = s_r.cnt + 1'b1;
                if (cntAt(s_r.cnt, ATTACH_LAST))
                begin
                    s_nxt.st = DS_READY;
                    s_nxt.cnt = '0;
                end
            end
            default:
            begin
                // An illegal state code restarts the power-on sequence.
                s_nxt.st = DS_POR;
                s_nxt.cnt = '0;
            end
        endcase
        // Until the power-on reset ends the pin is ignored, so power-on timing governs.
        if (s_r.st != DS_POR && extHeld)
        begin
            s_nxt.st = DS_HELD;
            s_nxt.cnt = '0;
            s_nxt.ack = 1'b0;
        end
        // Readiness is a registered level, so the master never sees a decode glitch.
        s_nxt.rdy = 1'b0;
        if ((s_nxt.st == DS_READY) && reachable)
        begin
            s_nxt.rdy = 1'b1;
        end
    end

    // Reset is synchronous, so the whole record takes its image on an edge.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_r <= DEV_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign link.cmdAck = s_r.ack;
    assign strapLatched = s_r.strap;
    assign porDone = s_r.porDone;
    assign smbReady = s_r.rdy;
    assign i2cSclHalf = s_r.half;

endmodule

// file: hrs_host.sv
// Board end: drives the hub reset and straps and paces the SMBus master.
// Assumes the hub end answers each command with a one-cycle acknowledge.
module hrs_host
    import hrs_pkg::*;
#(
    parameter int SW = STRAP_W,
    parameter int RST_CYC = RST_ASSERT_CYC,
    parameter int STRAP_CYC = STRAP_HOLD_CYC,
    parameter int READY_CYC = SMB_READY_CYC,
    parameter int ATTACH_CYC = ATTACH_READY_CYC
)
(
    // Clock and power-on reset.
    input wire logic mclk,
    input wire logic rst,
    // Link to the hub.
    hrs_link_if.host link,
    // Board control.
    input wire logic resetReq,
    input wire logic clkStable,
    input wire logic [SW-1:0] strapVal,
    input wire logic suspendReq,
    input wire logic forceClocks,
    // SMBus master requests.
    input wire logic cmdReq,
    input wire logic [15:0] cmdReqCode,
    output logic cmdReady,
    output logic cmdDone,
    output logic busQuiet
);

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        hrs_host_state_t st;
        logic [CNT_W-1:0] rstCnt;
        logic [CNT_W-1:0] holdCnt;
        logic [CNT_W-1:0] gapCnt;
        logic rstN;
        logic [SW-1:0] strap;
        logic valid;
        logic [15:0] code;
        logic done;
        logic susp;
        logic clkOn;
    } hrs_host_t;

    // Power-up counts as a release, so straps and bus wait from the start.
    localparam hrs_host_t HOST_RESET = '{st: HS_RUN, rstCnt: '0, holdCnt: CNT_W'(STRAP_CYC),
                                         gapCnt: CNT_W'(READY_CYC), rstN: 1'b1, strap: '0,
                                         valid: 1'b0, code: '0, done: 1'b0, susp: 1'b0, clkOn: 1'b0};

    hrs_host_t s_r;
    hrs_host_t s_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.susp = suspendReq;
        s_nxt.clkOn = forceClocks;
        if (s_r.holdCnt != '0)
        begin
            s_nxt.holdCnt = s_r.holdCnt - 1'b1;
        end
        if (s_r.gapCnt != '0)
        begin
            s_nxt.gapCnt = s_r.gapCnt - 1'b1;
        end
        // Straps follow the board value only outside the hold window.
        if (s_r.holdCnt == '0)
        begin
            s_nxt.strap = strapVal;
        end
        unique case (s_r.st)
            HS_RUN:
            begin
                if (resetReq)
                begin
                    s_nxt.st = HS_ASSERT;
                    s_nxt.rstN = 1'b0;
                    s_nxt.rstCnt = '0;
                    s_nxt.valid = 1'b0;
                end
            end
            HS_ASSERT:
            begin
                // Reset stays low for the full least width.
                s_nxt.rstCnt = s_r.rstCnt + 1'b1;
                if (s_r.rstCnt == CNT_W'(RST_CYC - 1))
                begin
                    s_nxt.st = HS_WAIT_CLK;
                end
            end
            HS_WAIT_CLK:
            begin
                // Release only on a stable reference clock.
                if (clkStable)
                begin
                    s_nxt.st = HS_RUN;
                    s_nxt.rstN = 1'b1;
                    s_nxt.holdCnt = CNT_W'(STRAP_CYC);
                    s_nxt.gapCnt = CNT_W'(READY_CYC);
                end
            end
        endcase
        if (s_r.valid && link.cmdAck)
        begin
            s_nxt.valid = 1'b0;
            s_nxt.done = 1'b1;
            if (s_r.code == CMD_ATTACH_RUNTIME)
            begin
                s_nxt.gapCnt = CNT_W'(ATTACH_CYC);
            end
        end
        else if (cmdReady && cmdReq)
        begin
            s_nxt.valid = 1'b1;
            s_nxt.code = cmdReqCode;
        end
        // The board straps are valid from power-up, so they load while reset is held.
        if (rst)
        begin
            s_nxt = HOST_RESET;
            s_nxt.strap = strapVal;
        end
    end

    always_ff @(posedge mclk)
    begin
        s_r <= s_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The bus stays idle until the gap count expires.
    assign cmdReady = (s_r.st == HS_RUN) && !s_r.valid && (s_r.gapCnt == '0) && !resetReq;
    assign busQuiet = (s_r.gapCnt != '0);
    assign cmdDone = s_r.done;
    assign link.resetN = s_r.rstN;
    assign link.strapPins = s_r.strap;
    assign link.cmdValid = s_r.valid;
    assign link.cmdCode = s_r.code;
    assign link.hubSuspend = s_r.susp;
    assign link.clkForceOn = s_r.clkOn;

endmodule

// file: hrs_link_props.sv
// Checker for the hub sequencer link; it sees only the link signals.
// Assumes tb hands it the same shortened counts as both link ends.
module hrs_link_props
    import hrs_pkg::*;
#(
    parameter int SW = STRAP_W,
    parameter int STRAP_CYC = 20,
    parameter int READY_CYC = 100,
    parameter int ATTACH_CYC = 50
)
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Link signals.
    input wire logic resetN,
    input wire logic [SW-1:0] strapPins,
    input wire logic cmdValid,
    input wire logic [15:0] cmdCode,
    input wire logic cmdAck,
    input wire logic hubSuspend,
    input wire logic clkForceOn
);
    timeunit 1ns;
    timeprecision 1ps;
    int holdCnt;
    int quietCnt;
    int attachCnt;

    // The quiet windows load one short so a same-edge launch is never flagged.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            holdCnt <= STRAP_CYC;
            quietCnt <= READY_CYC - 1;
            attachCnt <= 0;
        end
        else
        begin
            holdCnt <= $rose(resetN) ? STRAP_CYC : (holdCnt > 0 ? holdCnt - 1 : 0);
            quietCnt <= $rose(resetN) ? READY_CYC - 1 : (quietCnt > 0 ? quietCnt - 1 : 0);
            if (cmdAck && cmdCode == CMD_ATTACH_RUNTIME)
                attachCnt <= ATTACH_CYC - 1;
            else if (attachCnt > 0)
                attachCnt <= attachCnt - 1;
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_pending;
        cmdValid && !cmdAck;
    endsequence
    sequence s_answered;
        cmdAck ##1 (!cmdAck && !cmdValid);
    endsequence

    a_valid_holds: assert property (s_pending |=> cmdValid && $stable(cmdCode))
        else $error("command changed before ack");
    a_ack_pulse: assert property (cmdAck |-> s_answered)
        else $error("ack not a single pulse");
    a_ack_cause: assert property (cmdAck |-> $past(cmdValid) && (!$past(hubSuspend) || $past(clkForceOn)))
        else $error("ack without valid or while hidden");
    a_reset_width: assert property ($fell(resetN) |-> !resetN [*4])
        else $error("reset pulse too short");
    a_strap_hold: assert property (holdCnt != 0 |-> $stable(strapPins))
        else $error("straps moved in hold window");
    a_ready_quiet: assert property (quietCnt != 0 |-> !cmdValid)
        else $error("command inside ready gap");
    a_attach_quiet: assert property (attachCnt != 0 |-> !cmdValid)
        else $error("command inside attach gap");
    a_reset_idle: assert property (!resetN |=> !cmdAck && !cmdValid)
        else $error("traffic while reset held");
endmodule

// file: tb.sv
// Bench joining both link ends; drives board and core sides, checks outputs.
// Assumes shortened counts: straps 20, ready 100, attach 50, reset pulse 4.
module tb;
    import hrs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin badCount++; $display("ERROR %0t: %s", $time, m); end end
    localparam int SC = 20;
    localparam int RC = 100;
    localparam int AC = 50;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic resetReq = 1'h0;
    logic clkStable = 1'h1;
    logic [7:0] strapVal = 8'hA5;
    logic suspendReq = 1'h0;
    logic forceClocks = 1'h0;
    logic cmdReq = 1'h0;
    logic [15:0] cmdReqCode = 16'h0000;
    logic i2cFastSel = 1'h0;
    logic [7:0] strapLatched;
    logic porDone;
    logic smbReady;
    logic [7:0] i2cSclHalf;
    logic cmdReady;
    logic cmdDone;
    logic busQuiet;
    logic done;
    int badCount = 0;
    int checked = 0;
    int cycles = 0;

    hrs_link_if #(.STRAP_W(8)) link ();
    hrs_device #(.STRAP_CYC(SC), .READY_CYC(RC), .ATTACH_CYC(AC)) hrs_device_inst (.mclk(mclk), .rst(rst),
        .link(link.device), .i2cFastSel(i2cFastSel), .strapLatched(strapLatched), .porDone(porDone),
        .smbReady(smbReady), .i2cSclHalf(i2cSclHalf));
    hrs_host #(.RST_CYC(4), .STRAP_CYC(SC), .READY_CYC(RC), .ATTACH_CYC(AC)) hrs_host_inst (.mclk(mclk),
        .rst(rst), .link(link.host), .resetReq(resetReq), .clkStable(clkStable), .strapVal(strapVal),
        .suspendReq(suspendReq), .forceClocks(forceClocks), .cmdReq(cmdReq), .cmdReqCode(cmdReqCode),
        .cmdReady(cmdReady), .cmdDone(cmdDone), .busQuiet(busQuiet));
    hrs_link_props #(.SW(8), .STRAP_CYC(SC), .READY_CYC(RC), .ATTACH_CYC(AC)) hrs_link_props_inst (.mclk(mclk),
        .rst(rst), .resetN(link.resetN), .strapPins(link.strapPins), .cmdValid(link.cmdValid),
        .cmdCode(link.cmdCode), .cmdAck(link.cmdAck), .hubSuspend(link.hubSuspend), .clkForceOn(link.clkForceOn));

    ////////////////////////////////////////////////////////////////
    always #25 mclk = ~mclk;

    // A hang must still reach the verdict, so the ceiling counts as a mismatch.
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            badCount++;
            wrapUp();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic waitDone(input int lim);
        int n;
        n = 0;
        done = 1'h0;
        while (!done && n < lim)
        begin
            tick(1);
            done = (cmdDone === 1'h1);
            n++;
        end
    endtask

    task automatic send(input logic [15:0] code, input int lim);
        int n;
        n = 0;
        while (cmdReady !== 1'h1 && n < 300)
        begin
            tick(1);
            n++;
        end
        cmdReq = 1'h1;
        cmdReqCode = code;
        tick(1);
        cmdReq = 1'h0;
        waitDone(lim);
    endtask

    task automatic wrapUp();
        if (badCount == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        tick(3);
        rst = 1'h0;
        tick(SC + 2);
        `CHK(porDone, 1'h1, "power-on phase not finished")
        `CHK(strapLatched, 8'hA5, "power-on straps wrong")
        tick(RC - SC - 6);
        `CHK(smbReady, 1'h0, "slave ready too early")
        `CHK(cmdReady, 1'h0, "master free too early")
        tick(8);
        `CHK(smbReady, 1'h1, "slave not ready after gap")
        `CHK(cmdReady, 1'h1, "master not free after gap")
        `CHK(i2cSclHalf, I2C_SM_HALF_CYC, "standard mode period")
        i2cFastSel = 1'h1;
        tick(2);
        `CHK(i2cSclHalf, I2C_FM_HALF_CYC, "fast mode period")
        send(16'h1234, 20);
        `CHK(done, 1'h1, "ordinary command lost")
        send(16'h5678, 20);
        `CHK(done, 1'h1, "back-to-back command lost")
        send(CMD_ATTACH_RUNTIME, 20);
        `CHK(done, 1'h1, "attach command lost")
        `CHK(smbReady, 1'h0, "ready inside attach gap")
        `CHK(busQuiet, 1'h1, "host not quiet after attach")
        tick(AC + 4);
        `CHK(smbReady, 1'h1, "not ready after attach gap")
        suspendReq = 1'h1;
        tick(3);
        `CHK(smbReady, 1'h0, "reachable in suspend")
        send(16'h1111, 20);
        `CHK(done, 1'h0, "answered in suspend")
        forceClocks = 1'h1;
        waitDone(10);
        `CHK(done, 1'h1, "forced clocks did not unblock")
        suspendReq = 1'h0;
        forceClocks = 1'h0;
        strapVal = 8'h3C;
        clkStable = 1'h0;
        resetReq = 1'h1;
        tick(1);
        resetReq = 1'h0;
        tick(10);
        `CHK(link.resetN, 1'h0, "reset released on unstable clock")
        `CHK(smbReady, 1'h0, "ready while reset held")
        clkStable = 1'h1;
        tick(3);
        `CHK(link.resetN, 1'h1, "reset not released")
        // A board change inside the hold window must miss the latch and reach the pins once the window closes.
        strapVal = 8'h5A;
        tick(SC + 6);
        `CHK(strapLatched, 8'h3C, "straps not relatched")
        `CHK(link.strapPins, 8'h5A, "straps frozen past hold window")
        tick(RC - SC - 10);
        `CHK(smbReady, 1'h0, "ready too early after reset")
        `CHK(cmdReady, 1'h0, "master free too early after reset")
        tick(10);
        `CHK(smbReady, 1'h1, "not ready after reset gap")
        `CHK(cmdReady, 1'h1, "master not free after reset gap")
        wrapUp();
    end
endmodule
